/* ic_regs.sv */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module ic_regs #(
  parameter int ADDR_W = ic_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Register port
  input logic [ADDR_W-1:0] addr,
  input logic [7:0] wr_data,
  input logic wr_en,
  input logic rd_en,
  output logic [7:0] rd_data,
  // Power management
  input logic low_power_entry,
  // Serial bus pins, data is open drain
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Interrupt
  output logic irq
);

  generate
    if (ADDR_W < ic_pkg::ADDR_W_MIN) begin : g_bad_width
      $error("ic_regs: ADDR_W too narrow for the register map");
    end
  endgenerate

  ic_shift_if sh ();

  ic_shift_eng u_eng (
    .clk(clk),
    .rst_n(rst_n),
    .sh(sh)
  );

  // Pin synchronisers
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
    end
  end

  // Registers
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] cr1_r, cr1_nxt;
  logic [7:0] own_r, own_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic mode_r, mode_nxt;
  logic mst_r, mst_nxt;
  logic trx_r, trx_nxt;
  logic bb_r, bb_nxt;
  logic pin_r, pin_nxt;
  logic aas_r, aas_nxt;
  logic ad0_r, ad0_nxt;
  logic lrb_r, lrb_nxt;
  logic arm_r, arm_nxt;
  logic [2:0] ists_r, ists_nxt;
  logic [2:0] imsk_r, imsk_nxt;
  logic [7:0] rd_data_r;
  logic irq_r;
  logic sda_o_r;
  logic sda_oe_r;

  // Address decode
  logic hit_pwr, hit_cr1, hit_cr2, hit_own, hit_data, hit_ists, hit_imsk;
  assign hit_pwr = (addr == ADDR_W'(ic_pkg::ADDR_PWR));
  assign hit_cr1 = (addr == ADDR_W'(ic_pkg::ADDR_CTRL_ONE));
  assign hit_cr2 = (addr == ADDR_W'(ic_pkg::ADDR_CTRL_TWO));
  assign hit_own = (addr == ADDR_W'(ic_pkg::ADDR_OWN));
  assign hit_data = (addr == ADDR_W'(ic_pkg::ADDR_DATA));
  assign hit_ists = (addr == ADDR_W'(ic_pkg::ADDR_IRQ_STS));
  assign hit_imsk = (addr == ADDR_W'(ic_pkg::ADDR_IRQ_MSK));

  // Write gating
  logic iface_on, wr_gate;
  logic wr_cr1, wr_cr2, wr_cr2_ok, wr_own, wr_dbuf;
  assign iface_on = pwr_r[ic_pkg::PWR_IFACE_EN_BIT];
  assign wr_gate = wr_en & iface_on;
  assign wr_cr1 = wr_gate & hit_cr1;
  assign wr_cr2 = wr_gate & hit_cr2;
  assign wr_cr2_ok = wr_cr2 & mode_r;
  assign wr_own = wr_gate & hit_own;
  assign wr_dbuf = wr_gate & hit_data;

  // Initialisation sources
  logic srst_fire, lp_init, mode_fall, clr_ctl, st_init, done, match;
  assign srst_fire = wr_cr2_ok & arm_r
                   & (wr_data[1:0] == ic_pkg::SRST_FIRE);
  assign lp_init = low_power_entry;
  assign mode_nxt = wr_cr2 ? wr_data[ic_pkg::CR2_MODE_BIT] : mode_r;
  assign mode_fall = mode_r & ~mode_nxt;
  assign clr_ctl = srst_fire | lp_init;
  assign st_init = clr_ctl | mode_fall;
  assign done = sh.done;
  // Zero own address therefore accepts a received 0x01 start byte
  assign match = (sh.rx_byte[7:1] == own_r[7:1]);

  // Next values
  assign pwr_nxt = (wr_en & hit_pwr) ? wr_data : pwr_r;
  assign cr1_nxt = clr_ctl ? ic_pkg::CTRL_ONE_RST
                 : wr_cr1 ? wr_data : cr1_r;
  assign own_nxt = clr_ctl ? ic_pkg::OWN_RST
                 : wr_own ? wr_data : own_r;
  assign tx_nxt = lp_init ? ic_pkg::DATA_RST
                : wr_dbuf ? wr_data : tx_r;
  assign rx_nxt = lp_init ? ic_pkg::DATA_RST
                : done ? sh.rx_byte : rx_r;
  assign mst_nxt = st_init ? 1'b0
                 : wr_cr2_ok ? wr_data[ic_pkg::CR2_MST_BIT] : mst_r;
  assign trx_nxt = st_init ? 1'b0
                 : wr_cr2_ok ? wr_data[ic_pkg::CR2_TRX_BIT] : trx_r;
  assign bb_nxt = st_init ? 1'b0
                : wr_cr2_ok ? wr_data[ic_pkg::CR2_BB_BIT] : bb_r;
  // A finished transfer wins over a release in the same cycle
  assign pin_nxt = st_init ? ic_pkg::PIN_RST
                 : done ? 1'b0
                 : wr_dbuf ? 1'b1
                 : wr_cr2_ok ? wr_data[ic_pkg::CR2_PIN_BIT] : pin_r;
  assign aas_nxt = (srst_fire | mode_fall) ? 1'b0
                 : (done & ~mst_r) ? match : aas_r;
  assign ad0_nxt = (srst_fire | mode_fall) ? 1'b0
                 : (done & ~mst_r) ? (sh.rx_byte == 8'h00) : ad0_r;
  assign lrb_nxt = (srst_fire | mode_fall) ? 1'b0
                 : done ? sh.rx_byte[0] : lrb_r;
  assign arm_nxt = clr_ctl ? 1'b0
                 : wr_cr2_ok ? (wr_data[1:0] == ic_pkg::SRST_ARM) : arm_r;

  // Sticky interrupt status; a new event beats a clear
  logic [2:0] ev_set, ev_clr;
  assign ev_set[ic_pkg::IRQ_DONE_BIT] = done;
  assign ev_set[ic_pkg::IRQ_MATCH_BIT] = done & ~mst_r & match;
  assign ev_set[ic_pkg::IRQ_SRST_BIT] = srst_fire;
  assign ev_clr = (wr_en & hit_ists) ? wr_data[2:0] : 3'h0;
  assign ists_nxt = (ists_r & ~ev_clr) | ev_set;
  assign imsk_nxt = (wr_en & hit_imsk) ? wr_data[2:0] : imsk_r;

  // Read mux
  logic [7:0] status_val, rd_mux;
  assign status_val = {mst_r, trx_r, bb_r, pin_r, 1'b0, aas_r, ad0_r,
                       lrb_r};
  assign rd_mux = hit_pwr ? pwr_r
                : hit_cr1 ? cr1_r
                : hit_cr2 ? status_val
                : hit_own ? own_r
                : hit_data ? rx_r
                : hit_ists ? {5'h00, ists_r}
                : hit_imsk ? {5'h00, imsk_r}
                : 8'h00;

  // Shift engine control
  logic [2:0] bc;
  assign bc = cr1_r[ic_pkg::CR1_BC_LSB +: 3];
  assign sh.clk_en = iface_on;
  assign sh.abort = st_init;
  assign sh.load = wr_dbuf & mode_r & ~sh.busy;
  assign sh.tx_byte = tx_nxt;
  assign sh.nbits = (bc == 3'h0) ? ic_pkg::FULL_BYTE_BITS : {1'b0, bc};
  assign sh.scl_rise = scl_s2_r & ~scl_s3_r;
  assign sh.sda_bit = sda_s2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_r <= ic_pkg::PWR_RST;
      cr1_r <= ic_pkg::CTRL_ONE_RST;
      own_r <= ic_pkg::OWN_RST;
      tx_r <= ic_pkg::DATA_RST;
      rx_r <= ic_pkg::DATA_RST;
      mode_r <= 1'b0;
      mst_r <= 1'b0;
      trx_r <= 1'b0;
      bb_r <= 1'b0;
      pin_r <= ic_pkg::PIN_RST;
      aas_r <= 1'b0;
      ad0_r <= 1'b0;
      lrb_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      cr1_r <= cr1_nxt;
      own_r <= own_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      mode_r <= mode_nxt;
      mst_r <= mst_nxt;
      trx_r <= trx_nxt;
      bb_r <= bb_nxt;
      pin_r <= pin_nxt;
      aas_r <= aas_nxt;
      ad0_r <= ad0_nxt;
      lrb_r <= lrb_nxt;
      arm_r <= arm_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ists_r <= ic_pkg::IRQ_RST;
      imsk_r <= ic_pkg::IRQ_RST;
      rd_data_r <= 8'h00;
      irq_r <= 1'b0;
      sda_o_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      ists_r <= ists_nxt;
      imsk_r <= imsk_nxt;
      rd_data_r <= rd_en ? rd_mux : 8'h00;
      irq_r <= |(ists_r & imsk_r);
      sda_o_r <= 1'b0;
      sda_oe_r <= sh.drive_low & trx_r & mode_r;
    end
  end

  assign rd_data = rd_data_r;
  assign irq = irq_r;
  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;

endmodule

/* ic_pkg.sv */
package ic_pkg;

  localparam int ADDR_W_DEF = 12;
  localparam int ADDR_W_MIN = 12;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;

  localparam logic [11:0] ADDR_CTRL_ONE = 12'h022;
  localparam logic [11:0] ADDR_CTRL_TWO = 12'h023;
  localparam logic [11:0] ADDR_OWN = 12'h024;
  localparam logic [11:0] ADDR_DATA = 12'h025;
  localparam logic [11:0] ADDR_IRQ_STS = 12'h026;
  localparam logic [11:0] ADDR_IRQ_MSK = 12'h027;
  localparam logic [11:0] ADDR_PWR = 12'hF75;

  localparam int PWR_IFACE_EN_BIT = 4;
  localparam int CR1_BC_LSB = 5;
  localparam int CR2_MST_BIT = 7;
  localparam int CR2_TRX_BIT = 6;
  localparam int CR2_BB_BIT = 5;
  localparam int CR2_PIN_BIT = 4;
  localparam int CR2_MODE_BIT = 3;

  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic PIN_RST = 1'b1;

  localparam logic [1:0] SRST_ARM = 2'h2;
  localparam logic [1:0] SRST_FIRE = 2'h1;
  localparam logic [3:0] FULL_BYTE_BITS = 4'h8;

  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam int IRQ_SRST_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef enum logic [1:0] {
    IC_SH_IDLE = 2'b01,
    IC_SH_RUN = 2'b10
  } ic_shift_state_t;

endpackage

/* ic_shift_if.sv */
`timescale 1ns/1ps
interface ic_shift_if;
  logic clk_en;
  logic abort;
  logic load;
  logic [7:0] tx_byte;
  logic [3:0] nbits;
  logic scl_rise;
  logic sda_bit;
  logic [7:0] rx_byte;
  logic done;
  logic busy;
  logic drive_low;

  modport ctl (
    output clk_en, abort, load, tx_byte, nbits, scl_rise, sda_bit,
    input rx_byte, done, busy, drive_low
  );
  modport eng (
    input clk_en, abort, load, tx_byte, nbits, scl_rise, sda_bit,
    output rx_byte, done, busy, drive_low
  );
endinterface

/* ic_shift_eng.sv */
`timescale 1ns/1ps
module ic_shift_eng (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Control side
  ic_shift_if.eng sh
);

  logic en_lat;
  logic en_src;
  logic gclk;
  ic_pkg::ic_shift_state_t state_r;
  logic [7:0] shreg_r;
  logic [3:0] cnt_r;
  logic done_r;

  // Held open during reset so the engine still sees its reset
  assign en_src = sh.clk_en | ~rst_n;

  // Latch while clk is low so the gated clock never glitches
  always_latch begin
    if (!clk) begin
      en_lat <= en_src;
    end
  end

  assign gclk = clk & en_lat;

  always_ff @(posedge gclk) begin
    if (!rst_n || sh.abort) begin
      state_r <= ic_pkg::IC_SH_IDLE;
      shreg_r <= ic_pkg::DATA_RST;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        ic_pkg::IC_SH_IDLE: begin
          if (sh.load) begin
            shreg_r <= sh.tx_byte;
            cnt_r <= sh.nbits;
            state_r <= ic_pkg::IC_SH_RUN;
          end
        end
        ic_pkg::IC_SH_RUN: begin
          if (sh.scl_rise) begin
            shreg_r <= {shreg_r[6:0], sh.sda_bit};
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
              done_r <= 1'b1;
              state_r <= ic_pkg::IC_SH_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign sh.rx_byte = shreg_r;
  assign sh.done = done_r;
  assign sh.busy = (state_r == ic_pkg::IC_SH_RUN);
  assign sh.drive_low = sh.busy & ~shreg_r[7];

endmodule

/* ic_regs_checker.sv */
`timescale 1ns/1ps
module ic_regs_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Register port
  input logic [ADDR_W-1:0] addr,
  input logic [7:0] wr_data,
  input logic wr_en,
  input logic rd_en,
  input logic [7:0] rd_data,
  // Pins and interrupt
  input logic low_power_entry,
  input logic scl_i,
  input logic sda_i,
  input logic sda_o,
  input logic sda_oe,
  input logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] pwr_r;
  logic [2:0] msk_r;
  logic mode_r;
  wire [11:0] a = addr[11:0];
  wire w_pwr = wr_en && a == ic_pkg::ADDR_PWR;
  wire w_msk = wr_en && a == ic_pkg::ADDR_IRQ_MSK;
  wire w_mode = wr_en && a == ic_pkg::ADDR_CTRL_TWO && pwr_r[4];
  wire r_sts = rd_en && a == ic_pkg::ADDR_CTRL_TWO;
  // Shadow copies so reads can be judged without seeing the bodies
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_r <= 8'h00;
      msk_r <= 3'h0;
      mode_r <= 1'b0;
    end else begin
      if (w_pwr)
        pwr_r <= wr_data;
      if (w_msk)
        msk_r <= wr_data[2:0];
      if (w_mode)
        mode_r <= wr_data[3];
    end
  end
  sequence s_mask_off;
    w_msk && wr_data[2:0] == 3'h0;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> rd_data == 8'h00 && !irq && !sda_oe)
    else $error("outputs not quiet after reset");
  chk_rd_idle_zero: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data without read strobe");
  chk_unmapped_rd: assert property (rd_en && a[11:8] == 4'h1
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  chk_gate_readback: assert property (
    rd_en && a == ic_pkg::ADDR_PWR |=> rd_data == $past(pwr_r))
    else $error("power gate read mismatch");
  chk_mask_readback: assert property (rd_en && a == ic_pkg::ADDR_IRQ_MSK
    |=> rd_data[2:0] == $past(msk_r)) else $error("mask read mismatch");
  chk_status_idle: assert property (
    r_sts && !mode_r |=> rd_data == 8'h10)
    else $error("status not initial while mode off");
  chk_lost_bit_zero: assert property (r_sts |=> !rd_data[3])
    else $error("status bit 3 set");
  chk_sda_low: assert property (!sda_o)
    else $error("data pin driven high");
  chk_oe_needs_mode: assert property (
    !mode_r && !$past(mode_r) |-> !sda_oe)
    else $error("data pin pulled with mode off");
  chk_irq_masked: assert property (s_mask_off |-> ##2 !irq)
    else $error("interrupt high with mask clear");
endmodule

bind ic_regs ic_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
  .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .low_power_entry(low_power_entry),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .irq(irq));

/* ic_regs_tb.sv */
`timescale 1ns/1ps
module ic_regs_tb;
  logic clk, rst_n, wr_en, rd_en, lpe, scl, sda_drv, sda_o, sda_oe, irq;
  logic [11:0] addr;
  logic [7:0] wr_data, rd_data, v, tx, rx;
  logic [15:0] seed = 16'hD79A;
  int bad_count, n_checks;
  // Open-drain data line: low while the block pulls it
  wire sda_i = sda_drv & ~sda_oe;
  ic_regs dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .low_power_entry(lpe), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] sts(input logic [7:0] r, o);
    return {5'h00, r[7:1] == o[7:1], r == 8'h00, r[0]};
  endfunction
  task automatic check(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask
  // Six cycles a phase leaves room for the three-flop pin delay
  task automatic shift_byte(input logic [7:0] t, d);
    for (int i = 7; i >= 0; i--) begin
      scl <= 1'b0;
      sda_drv <= d[i];
      repeat (6) @(posedge clk);
      #1;
      check({7'h0, sda_oe}, {7'h0, ~t[i]});
      scl <= 1'b1;
      repeat (6) @(posedge clk);
    end
    sda_drv <= 1'b1;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1;
    check({7'h0, irq}, {7'h0, e});
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test;
  end
  initial begin
    rst_n = 1'b0;
    {wr_en, rd_en, lpe, addr, wr_data} = '0;
    {scl, sda_drv} = 2'b11;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'hF75, 8'h00);
    rd(12'h023, 8'h10);
    rd(12'h100, 8'h00);
    wr(12'h024, 8'h5A);
    wr(12'h022, 8'hE3);
    rd(12'h024, 8'h00);
    rd(12'h022, 8'h00);
    wr(12'hF75, 8'h10);
    rd(12'hF75, 8'h10);
    wr(12'h023, 8'hF4);
    rd(12'h023, 8'h10);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      wr(12'h024, v | 8'h02);
      rd(12'h024, v | 8'h02);
      v = rnd();
      wr(12'h022, v);
      rd(12'h022, v);
    end
    wr(12'h023, 8'h08);
    wr(12'h023, 8'h0A);
    wr(12'h023, 8'h09);
    rd(12'h022, 8'h00);
    rd(12'h024, 8'h00);
    rd(12'h023, 8'h10);
    rd(12'h026, 8'h04);
    wr(12'h027, 8'h04);
    irq_is(1'b1);
    wr(12'h027, 8'h00);
    irq_is(1'b0);
    wr(12'h027, 8'h04);
    irq_is(1'b1);
    wr(12'h026, 8'h04);
    irq_is(1'b0);
    rd(12'h026, 8'h00);
    wr(12'h024, 8'h3C);
    wr(12'h023, 8'h48);
    tx = rnd();
    v = rnd();
    wr(12'h025, tx);
    rd(12'h023, 8'h50);
    shift_byte(tx, v);
    rx = v & tx;
    rd(12'h025, rx);
    rd(12'h023, sts(rx, 8'h3C) | 8'h40);
    rd(12'h026, {6'h0, rx[7:1] == 7'h1E, 1'b1});
    // Corner case: the received byte equals the own address
    wr(12'h025, 8'hBE);
    rd(12'h023, sts(rx, 8'h3C) | 8'h50);
    shift_byte(8'hBE, 8'h3D);
    rx = 8'h3C;
    rd(12'h025, rx);
    rd(12'h023, sts(rx, 8'h3C) | 8'h40);
    rd(12'h026, 8'h03);
    @(posedge clk);
    lpe <= 1'b1;
    @(posedge clk);
    lpe <= 1'b0;
    rd(12'h022, 8'h00);
    rd(12'h024, 8'h00);
    rd(12'h025, 8'h00);
    rd(12'h023, sts(rx, 8'h3C) | 8'h10);
    wr(12'h023, 8'h00);
    rd(12'h023, 8'h10);
    wr(12'hF75, 8'h00);
    wr(12'h024, 8'h77);
    rd(12'h024, 8'h00);
    finish_test;
  end
endmodule
